// ===== hdl/edge_sync.sv
// Two-stage synchroniser with a one-cycle rising edge pulse
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic async_in,
   output logic rise_pulse
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // Only sync_reg reads meta_reg; the edge detector looks at later stages
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign rise_pulse = sync_reg & ~last_reg;
endmodule
`default_nettype wire

// ===== hdl/timer3_defs.svh
// Constants for the reload/capture timer: register offsets, fields and timing
`ifndef TIMER3_DEFS_SVH
`define TIMER3_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_CONTROL 8'h91
`define ADDR_RELOAD_LOW 8'h92
`define ADDR_RELOAD_HIGH 8'h93
`define ADDR_COUNT_LOW 8'h94
`define ADDR_COUNT_HIGH 8'h95
`define ADDR_CLOCK_CTRL 8'h96
`define ADDR_IRQ_ENABLE 8'h97
`define ADDR_IRQ_STATUS 8'h98
`define ADDR_IRQ_MASK 8'h99

// ****************************************
// Control register fields
// ****************************************
`define CTL_HIGH_FLAG 7
`define CTL_LOW_FLAG 6
`define CTL_LOW_IRQ_EN 5
`define CTL_CAPTURE_EN 4
`define CTL_SPLIT 3
`define CTL_RUN 2
`define CTL_XCLK_HI 1
`define CTL_XCLK_LO 0

// Clock control fields
`define CKC_HIGH_SYSTEM_CLOCK 1
`define CKC_LOW_SYSTEM_CLOCK 0

// Extended interrupt enable field
`define EIE_TIMER_EN 7

// Status / mask fields
`define ST_HIGH_OVF 0
`define ST_LOW_OVF 1
`define ST_CAPTURE 2

// ****************************************
// Reset values and timing
// ****************************************
`define RESET_BYTE 8'h00
`define BYTE_ALL_ONES 8'hff
`define PRESCALE_DIV 12
`define PRESCALE_TOP 4'hb
`define XCLK_SYS12 2'h0
`define XCLK_RTC 2'h1
`define XCLK_EXT8 2'h3

`endif

// ===== hdl/timer3_pkg.sv
// Types shared by the reload/capture timer
package timer3_pkg;
   typedef struct packed {
      logic high_flag;
      logic low_flag;
      logic low_irq_en;
      logic capture_en;
      logic split;
      logic run;
      logic [1:0] alt_clock_select;
   } control_type;

   typedef struct packed {
      logic sys12;
      logic rtc;
      logic ext8;
   } ticks_type;
endpackage

// ===== hdl/timer3_reload_capture.sv
// Reload/capture timer: 16-bit or split 8-bit counting, capture mode, register port
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "timer3_defs.svh"

// Function
// RULE_01: Two bytes form 16-bit count; split selects
// RULE_02: Slow sources synchronised before use
// RULE_03: 16-bit wrap reloads, sets high flag
// RULE_04: Timer enable requests interrupt each overflow
// RULE_05: Low-byte interrupt also on low wraps
// RULE_06: Split bytes reload from own reload
// RULE_07: Run gates high byte only in split
// RULE_08: System_clock select else alternate clock choice
// RULE_09: Split sets high/low flags on wraps
// RULE_10: Split interrupts on high, optionally low
// RULE_11: Flags cleared only by software
// RULE_12: Capture enable bit selects capture mode
// RULE_13: Select bit one picks capture trigger
// RULE_14: Capture copies count, sets high flag
// RULE_15: Software derives period from capture differences
// RULE_16: Control register layout, reset zero
// RULE_17: Capture mode counts freely without reload
// RULE_18: One enable pulse per source edge
module timer3_reload_capture (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   input wire logic rtc_clk_in,
   input wire logic ext_osc_in,
   output logic timer_irq,
   output logic irq_out
);
   timer3_pkg::control_type ctl_reg;
   logic [7:0] count_low_byte;
   logic [7:0] count_high_byte;
   logic [7:0] reload_low_byte;
   logic [7:0] reload_high_byte;
   logic [7:0] clock_control_reg;
   logic [7:0] extended_irq_enable_reg;
   logic [2:0] irq_status_reg;
   logic [2:0] irq_mask_reg;
   logic [7:0] rdata_reg;
   logic timer_irq_reg;
   logic irq_out_reg;
   logic [3:0] prescale_reg;
   logic [2:0] ext_div_reg;
   logic ext_rise;
   logic rtc_rise;
   logic ext8_tick;
   timer3_pkg::ticks_type ticks;

   // ****************************************
   // Source synchronisation
   // ****************************************
   edge_sync u_ext_sync (
      .core_clk(core_clk),
      .srst(srst),
      .async_in(ext_osc_in),
      .rise_pulse(ext_rise)
   ); // RULE_02
   edge_sync u_rtc_sync (
      .core_clk(core_clk),
      .srst(srst),
      .async_in(rtc_clk_in),
      .rise_pulse(rtc_rise)
   ); // RULE_02

   // Divide-by-8 counts synchronised oscillator edges, so it needs the oscillator well below
   // half the core clock rate
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ext_div_reg <= 3'h0;
         prescale_reg <= 4'h0;
      end else begin
         if (ext_rise) begin
            ext_div_reg <= ext_div_reg + 3'h1;
         end
         prescale_reg <= (prescale_reg == `PRESCALE_TOP) ? 4'h0 : prescale_reg + 4'h1;
      end
   end

   assign ext8_tick = ext_rise && (ext_div_reg == 3'h7); // RULE_18
   assign ticks.sys12 = (prescale_reg == `PRESCALE_TOP);
   assign ticks.rtc = rtc_rise; // RULE_18
   assign ticks.ext8 = ext8_tick;

   // ****************************************
   // Clock selection
   // ****************************************
   function automatic logic pick_tick(input logic system_clock_sel, input logic [1:0] xsel,
                                      input timer3_pkg::ticks_type t);
      logic r;
      r = 1'b0;
      if (system_clock_sel) begin
         r = 1'b1;
      end else begin
         unique case (xsel)
            `XCLK_SYS12: r = t.sys12;
            `XCLK_RTC: r = t.rtc;
            `XCLK_EXT8: r = t.ext8;
            default: r = 1'b0;
         endcase
      end
      return r;
   endfunction

   wire capture_mode = ctl_reg.capture_en; // RULE_12
   wire split_mode_sel = ctl_reg.split & ~capture_mode;
   wire run_control = ctl_reg.run;
   wire low_tick = pick_tick(clock_control_reg[`CKC_LOW_SYSTEM_CLOCK], ctl_reg.alt_clock_select,
                             ticks); // RULE_08
   wire high_tick = pick_tick(clock_control_reg[`CKC_HIGH_SYSTEM_CLOCK], ctl_reg.alt_clock_select,
                              ticks); // RULE_08
   // Trigger is rtc rising edge or every eighth oscillator cycle
   wire capture_event = capture_mode &&
                        (ctl_reg.alt_clock_select[1] ? ext8_tick : rtc_rise); // RULE_13

   // ****************************************
   // Counter datapath
   // ****************************************
   wire [15:0] count16 = {count_high_byte, count_low_byte};
   wire full_adv = ~split_mode_sel & run_control & low_tick;
   wire full_wrap = full_adv && (count16 == 16'hffff);
   wire low_adv = split_mode_sel ? low_tick : full_adv; // RULE_07
   wire low_wrap = low_adv && (count_low_byte == `BYTE_ALL_ONES); // RULE_05
   wire high_adv = split_mode_sel & run_control & high_tick; // RULE_07
   wire high_wrap = high_adv && (count_high_byte == `BYTE_ALL_ONES);
   wire set_high = split_mode_sel ? high_wrap : (full_wrap | capture_event); // RULE_09
   // A full 16-bit wrap reloads outside capture mode; it sets only the high flag, never the low flag
   wire set_low = split_mode_sel ? low_wrap : (low_wrap & ~full_wrap); // RULE_05 RULE_09
   wire reload16 = full_wrap & ~capture_mode; // RULE_03 RULE_17

   wire [15:0] count16_next = count16 + 16'h0001;
   wire [7:0] low_next = count_low_byte + 8'h01;
   wire [7:0] high_next = count_high_byte + 8'h01;

   wire wr_ctl = wr_en && (addr == `ADDR_CONTROL);
   wire wr_rll = wr_en && (addr == `ADDR_RELOAD_LOW);
   wire wr_rlh = wr_en && (addr == `ADDR_RELOAD_HIGH);
   wire wr_cl = wr_en && (addr == `ADDR_COUNT_LOW);
   wire wr_ch = wr_en && (addr == `ADDR_COUNT_HIGH);
   wire rd_status = rd_en && (addr == `ADDR_IRQ_STATUS);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         count_low_byte <= `RESET_BYTE;
         count_high_byte <= `RESET_BYTE;
      end else if (!split_mode_sel) begin
         if (reload16) begin
            count_low_byte <= reload_low_byte; // RULE_03
            count_high_byte <= reload_high_byte;
         end else if (full_adv) begin
            {count_high_byte, count_low_byte} <= count16_next; // RULE_01 RULE_17
         end else begin
            if (wr_cl) count_low_byte <= wdata;
            if (wr_ch) count_high_byte <= wdata;
         end
      end else begin
         if (low_wrap) count_low_byte <= reload_low_byte; // RULE_06
         else if (low_adv) count_low_byte <= low_next;
         else if (wr_cl) count_low_byte <= wdata;
         if (high_wrap) count_high_byte <= reload_high_byte; // RULE_06
         else if (high_adv) count_high_byte <= high_next;
         else if (wr_ch) count_high_byte <= wdata;
      end
   end

   // Capture wins over a software write to the reload bytes in the same cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         reload_low_byte <= `RESET_BYTE;
         reload_high_byte <= `RESET_BYTE;
      end else if (capture_event) begin
         reload_low_byte <= count_low_byte; // RULE_14
         reload_high_byte <= count_high_byte;
      end else begin
         if (wr_rll) reload_low_byte <= wdata;
         if (wr_rlh) reload_high_byte <= wdata;
      end
   end

   // ****************************************
   // Control and flags
   // ****************************************
   // Hardware set beats a software clear; hardware never clears a flag
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctl_reg <= '0; // RULE_16
      end else begin
         if (wr_ctl) ctl_reg <= wdata;
         if (set_high) ctl_reg.high_flag <= 1'b1; // RULE_11 RULE_14
         if (set_low) ctl_reg.low_flag <= 1'b1; // RULE_09
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         clock_control_reg <= `RESET_BYTE;
         extended_irq_enable_reg <= `RESET_BYTE;
         irq_mask_reg <= 3'h0;
      end else begin
         if (wr_en && addr == `ADDR_CLOCK_CTRL) clock_control_reg <= wdata;
         if (wr_en && addr == `ADDR_IRQ_ENABLE) extended_irq_enable_reg <= wdata;
         if (wr_en && addr == `ADDR_IRQ_MASK) irq_mask_reg <= wdata[2:0];
      end
   end

   wire [2:0] status_set = {capture_event, set_low, set_high & ~capture_event};
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_status_reg <= 3'h0;
      end else if (rd_status) begin
         irq_status_reg <= status_set;
      end else begin
         irq_status_reg <= irq_status_reg | status_set;
      end
   end

   // ****************************************
   // Interrupt request and read port
   // ****************************************
   wire timer_en = extended_irq_enable_reg[`EIE_TIMER_EN];
   // Request follows flags: high always, low only with its enable
   wire timer_req = timer_en &&
                    (ctl_reg.high_flag || (ctl_reg.low_irq_en && ctl_reg.low_flag)); // RULE_04 RULE_10

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (addr)
         `ADDR_CONTROL: rd_mux = ctl_reg;
         `ADDR_RELOAD_LOW: rd_mux = reload_low_byte;
         `ADDR_RELOAD_HIGH: rd_mux = reload_high_byte;
         `ADDR_COUNT_LOW: rd_mux = count_low_byte;
         `ADDR_COUNT_HIGH: rd_mux = count_high_byte;
         `ADDR_CLOCK_CTRL: rd_mux = clock_control_reg;
         `ADDR_IRQ_ENABLE: rd_mux = extended_irq_enable_reg;
         `ADDR_IRQ_STATUS: rd_mux = {5'h00, irq_status_reg};
         `ADDR_IRQ_MASK: rd_mux = {5'h00, irq_mask_reg};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_reg <= 8'h00;
         timer_irq_reg <= 1'b0;
         irq_out_reg <= 1'b0;
      end else begin
         rdata_reg <= rd_en ? rd_mux : 8'h00;
         timer_irq_reg <= timer_req;
         irq_out_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   assign rdata = rdata_reg;
   assign timer_irq = timer_irq_reg;
   assign irq_out = irq_out_reg;

   // ****************************************
   // Checks
   // ****************************************
   property p_wrap_reload;
      @(posedge core_clk) disable iff (srst)
      reload16 |=> (count16 == $past({reload_high_byte, reload_low_byte}));
   endproperty
   a_wrap_reload: assert property (p_wrap_reload) else $error("no reload on wrap"); // RULE_03

   property p_high_flag;
      @(posedge core_clk) disable iff (srst)
      set_high |=> ctl_reg.high_flag;
   endproperty
   a_high_flag: assert property (p_high_flag) else $error("high flag not set"); // RULE_09

   property p_low_flag;
      @(posedge core_clk) disable iff (srst)
      set_low |=> ctl_reg.low_flag;
   endproperty
   a_low_flag: assert property (p_low_flag) else $error("low flag not set"); // RULE_09

   property p_no_hw_clear;
      @(posedge core_clk) disable iff (srst)
      (ctl_reg.high_flag && !wr_ctl) |=> ctl_reg.high_flag;
   endproperty
   a_no_hw_clear: assert property (p_no_hw_clear) else $error("flag cleared"); // RULE_11

   property p_capture;
      @(posedge core_clk) disable iff (srst)
      capture_event |=> ({reload_high_byte, reload_low_byte} == $past(count16));
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong"); // RULE_14

   property p_irq;
      @(posedge core_clk) disable iff (srst)
      (timer_en && set_high) |-> ##2 timer_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("no interrupt"); // RULE_04

   property p_split_high_hold;
      @(posedge core_clk) disable iff (srst)
      (split_mode_sel && !run_control && !wr_ch) |=> $stable(count_high_byte);
   endproperty
   a_split_high_hold: assert property (p_split_high_hold) else $error("high ran"); // RULE_07

   property p_capture_free;
      @(posedge core_clk) disable iff (srst)
      (capture_mode && full_wrap) |=> (count16 == 16'h0000);
   endproperty
   a_capture_free: assert property (p_capture_free) else $error("capture reloaded"); // RULE_17

   property p_one_pulse;
      @(posedge core_clk) disable iff (srst)
      rtc_rise |=> !rtc_rise;
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("double pulse"); // RULE_18

   property p_low_irq;
      @(posedge core_clk) disable iff (srst)
      (timer_en && ctl_reg.low_irq_en && ctl_reg.low_flag) |=> timer_irq;
   endproperty
   a_low_irq: assert property (p_low_irq) else $error("no low interrupt"); // RULE_05

   property p_split_low_reload;
      @(posedge core_clk) disable iff (srst)
      (split_mode_sel && low_wrap) |=> (count_low_byte == $past(reload_low_byte));
   endproperty
   a_split_low_reload: assert property (p_split_low_reload) else $error("low no reload"); // RULE_06

   property p_split_high_reload;
      @(posedge core_clk) disable iff (srst)
      (split_mode_sel && high_wrap) |=> (count_high_byte == $past(reload_high_byte));
   endproperty
   a_split_high_reload: assert property (p_split_high_reload) else $error("high no reload"); // RULE_06

   property p_split_low_runs;
      @(posedge core_clk) disable iff (srst)
      (split_mode_sel && low_tick && !low_wrap) |=>
         (count_low_byte == $past(count_low_byte) + 8'h01);
   endproperty
   a_split_low_runs: assert property (p_split_low_runs) else $error("low stalled"); // RULE_07
endmodule
`default_nettype wire

// ===== tb/osc_sources.sv
// Model of the slow oscillator sources outside the timer
`timescale 1ns/100ps
`default_nettype none
module osc_sources (
   output logic rtc_clk_in,
   output logic ext_osc_in
);
   // Both clocks stand low between bursts, far slower than core_clk
   initial begin
      rtc_clk_in = 1'b0;
      ext_osc_in = 1'b0;
   end

   task automatic rtc_edges(input int n);
      repeat (n) begin
         #40 rtc_clk_in = 1'b1;
         #40 rtc_clk_in = 1'b0;
      end
   endtask

   task automatic ext_edges(input int n);
      repeat (n) begin
         #25 ext_osc_in = 1'b1;
         #25 ext_osc_in = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ===== tb/tb_timer3_reload_capture.sv
// Self-checking bench for the reload/capture timer
`timescale 1ns/100ps
`default_nettype none
module tb_timer3_reload_capture;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [7:0] rdata;
   logic rtc_clk_in;
   logic ext_osc_in;
   logic timer_irq;
   logic irq_out;
   int errors = 0;
   int n_checks = 0;
   logic [7:0] v;
   logic [7:0] lo_t [4] = '{8'h0c, 8'h03, 8'h00, 8'h02};
   logic [7:0] hi_t [4] = '{8'h10, 8'h03, 8'h00, 8'h02};

   always #2.5 core_clk = ~core_clk;

   timer3_reload_capture i_timer3_reload_capture (
      .core_clk(core_clk),
      .srst(srst),
      .addr(addr),
      .wdata(wdata),
      .wr_en(wr_en),
      .rd_en(rd_en),
      .rdata(rdata),
      .rtc_clk_in(rtc_clk_in),
      .ext_osc_in(ext_osc_in),
      .timer_irq(timer_irq),
      .irq_out(irq_out)
   );

   osc_sources i_osc_sources (.rtc_clk_in(rtc_clk_in), .ext_osc_in(ext_osc_in));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic complete_run;
      if (errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         errors++;
      end
   endtask

   // Each access ends with its strobe low, so a following call starts on a fresh edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask

   task automatic wrs(input logic [15:0] s [$]);
      foreach (s[k]) wr(s[k][15:8], s[k][7:0]);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1 v = rdata;
      chk(v & m, exp);
   endtask

   task automatic wait_irq(input logic lvl);
      int i;
      for (i = 0; i < 400 && timer_irq !== lvl; i++) @(posedge core_clk);
      chk({7'h00, timer_irq}, {7'h00, lvl});
      if (timer_irq !== lvl) begin
         complete_run();
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic sc_reset;
      for (int a = 8'h91; a <= 8'h99; a++) rchk(8'(a), 8'hff, 8'h00);
      rchk(8'ha0, 8'hff, 8'h00);
      chk({7'h00, timer_irq}, 8'h00);
   endtask

   task automatic sc_overflow16;
      wrs('{16'h9603, 16'h9234, 16'h9312, 16'h95ff, 16'h94fd, 16'h9780, 16'h9901, 16'h9104});
      wait_irq(1'b1);
      wrs('{16'h9180});
      rchk(8'h95, 8'hff, 8'h12);
      rchk(8'h91, 8'hff, 8'h80);
      chk({7'h00, irq_out}, 8'h01);
      rchk(8'h98, 8'h01, 8'h01);
      rchk(8'h98, 8'hff, 8'h00);
      wrs('{16'h9100});
      wait_irq(1'b0);
      chk({7'h00, irq_out}, 8'h00);
   endtask

   task automatic sc_low16;
      wrs('{16'h9500, 16'h94fe, 16'h9124});
      wait_irq(1'b1);
      wrs('{16'h9160});
      rchk(8'h91, 8'hff, 8'h60);
      rchk(8'h95, 8'hff, 8'h01);
      wrs('{16'h9120});
      wait_irq(1'b0);
      wrs('{16'h9100});
   endtask

   task automatic sc_split;
      wrs('{16'h9210, 16'h9555, 16'h94fe, 16'h9128});
      wait_irq(1'b1);
      wrs('{16'h9140});
      rchk(8'h95, 8'hff, 8'h55);
      rchk(8'h91, 8'hff, 8'h40);
      rchk(8'h94, 8'hf0, 8'h10);
      wrs('{16'h9100});
   endtask

   task automatic sc_capture_rtc;
      // Split stays clear while capturing
      wrs('{16'h9500, 16'h9400, 16'h9114});
      i_osc_sources.rtc_edges(1);
      wait_irq(1'b1);
      wrs('{16'h9180});
      rchk(8'h93, 8'hff, 8'h00);
      chk({7'h00, timer_irq}, 8'h01);
      rchk(8'h92, 8'hf0, 8'h00);
      chk({7'h00, v !== 8'h00}, 8'h01);
      rchk(8'h98, 8'h04, 8'h04);
      wrs('{16'h9100});
   endtask

   task automatic sc_sources;
      wrs('{16'h9600});
      for (int c = 0; c < 4; c++) begin
         wrs('{16'h9500, 16'h9400, {8'h91, 6'h01, 2'(c)}});
         fork
            i_osc_sources.rtc_edges(3);
            i_osc_sources.ext_edges(16);
         join
         repeat (4) @(posedge core_clk);
         wrs('{16'h9100});
         rchk(8'h95, 8'hff, 8'h00);
         rchk(8'h94, 8'h00, 8'h00);
         chk({7'h00, v >= lo_t[c] && v <= hi_t[c]}, 8'h01);
      end
   endtask

   task automatic sc_capture_ext;
      wrs('{16'h9500, 16'h9400, 16'h9116});
      i_osc_sources.ext_edges(7);
      repeat (10) @(posedge core_clk);
      chk({7'h00, timer_irq}, 8'h00);
      i_osc_sources.ext_edges(1);
      wait_irq(1'b1);
      rchk(8'h98, 8'h04, 8'h04);
      wrs('{16'h9100});
   endtask

   initial begin
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      sc_reset();
      sc_overflow16();
      sc_low16();
      sc_split();
      sc_capture_rtc();
      sc_sources();
      sc_capture_ext();
      complete_run();
   end
endmodule
`default_nettype wire
